// ---- bench/fbp_link_checker.sv ----
// assertions on the backplane link between host end and device end
// assumes one clock sys_clk and synchronous active-high rst
`timescale 1ns/1ps
module fbp_link_checker #(
  parameter int BURST = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic poll,
  input wire logic unaryAddressResponse,
  input wire logic burstRequest,
  input wire logic sync,
  input wire logic ioStrobe,
  input wire logic transferDirection
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // strobes seen in the current sync phase
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  always_comb cnt_d = rst ? 6'h00 : (sync ? cnt_q + 6'(ioStrobe) : 6'h00);
  always_ff @(posedge sys_clk) cnt_q <= cnt_d;
  a_strobe_in_sync: assert property (ioStrobe |-> sync) else $error("strobe outside sync");
  a_strobe_gap: assert property (ioStrobe |=> !ioStrobe) else $error("strobe too long");
  a_answer_poll: assert property ($rose(unaryAddressResponse) |-> $past(poll))
    else $error("answer without poll");
  a_burst_answer: assert property (burstRequest |-> unaryAddressResponse)
    else $error("burst request alone");
  a_sync_answer: assert property ($rose(sync) |-> $past(unaryAddressResponse))
    else $error("sync without answer");
  a_burst_limit: assert property (cnt_q <= 6'h20) else $error("burst too long");
  a_word_count: assert property ($fell(sync) |-> (cnt_q == 6'h01 || cnt_q == 6'(BURST)))
    else $error("bad word count");
  a_dir_steady: assert property (sync |-> $stable(transferDirection))
    else $error("direction moved in sync");
  c_burst: cover property ($fell(sync) && cnt_q == 6'(BURST));
  c_single: cover property ($fell(sync) && cnt_q == 6'h01);
  c_refused: cover property (poll ##2 !poll && !sync);
endmodule : fbp_link_checker

// ---- bench/fifo_backplane_poll_transfer_tb_top.sv ----
// self-checking bench: host end and device end joined by the link
// assumes the shared defines header is on the include path
`timescale 1ns/1ps
`include "fbp_defs.svh"
module fifo_backplane_poll_transfer_tb_top;
  typedef logic [`FBP_DATA_WIDTH-1:0] fbp_word_t;
  typedef struct {logic out; logic burst; int n; int tot;} fbp_row_t;
  logic      sys_clk, rst, outputMode, frontShiftIn, frontShiftOut, start, preferBurst;
  logic      txTaken, rxValid, busy, frontInputReady, frontOutputReady;
  fbp_word_t frontDataIn, frontDataOut, txData, rxData;
  int        bad_count, n_compared, moved, tot;
  fbp_word_t q[$];
  fbp_row_t  rows[4] = '{'{1, 0, 3, 3}, '{0, 0, 4, 3}, '{1, 1, 40, 57}, '{0, 1, 10, 57}};
  fbp_link_if fbp_link_if_i ();
  fbp_device_end fbp_device_end_i (.sys_clk(sys_clk), .rst(rst), .link(fbp_link_if_i.dev),
    .outputMode(outputMode), .frontShiftIn(frontShiftIn), .frontDataIn(frontDataIn),
    .frontShiftOut(frontShiftOut), .frontDataOut(frontDataOut),
    .frontInputReady(frontInputReady), .frontOutputReady(frontOutputReady));
  fbp_host_end #(.BURST_LEN(8)) fbp_host_end_i (.sys_clk(sys_clk), .rst(rst),
    .link(fbp_link_if_i.host), .start(start), .preferBurst(preferBurst), .txData(txData),
    .txTaken(txTaken), .rxData(rxData), .rxValid(rxValid), .busy(busy));
  fbp_link_checker #(.BURST(8)) fbp_link_checker_i (.sys_clk(sys_clk), .rst(rst),
    .poll(fbp_link_if_i.poll), .unaryAddressResponse(fbp_link_if_i.unaryAddressResponse),
    .burstRequest(fbp_link_if_i.burstRequest), .sync(fbp_link_if_i.sync),
    .ioStrobe(fbp_link_if_i.ioStrobe), .transferDirection(fbp_link_if_i.transferDirection));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  task automatic chk_word(input fbp_word_t got, input fbp_word_t exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk_word
  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %0t bit %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  // words one poll should move, from occupancy, direction and burst wish
  function automatic int exp_words(input int occ, input logic out, input logic burst);
    if (out) return (occ > `FBP_FIFO_DEPTH - `FBP_BURST_MIN) ? 0 :
      (burst && occ > `FBP_ALMOST_GAP && occ < `FBP_FIFO_DEPTH / 2) ? 8 : 1;
    return (occ == 0) ? 0 : (burst && occ >= `FBP_BURST_MIN) ? 8 : 1;
  endfunction : exp_words
  // words crossing the link, in either direction
  always @(posedge sys_clk) begin
    if (txTaken === 1'b1) begin
      q.push_back(txData);
      txData <= txData + 16'h0001;
      moved++;
    end
    if (rxValid === 1'b1) begin
      chk_word(rxData, q.pop_front());
      moved++;
    end
  end
  task automatic xfer(input logic out, input logic burst);
    int e;
    int i;
    @(posedge sys_clk);
    outputMode <= out;
    preferBurst <= burst;
    repeat (2) @(posedge sys_clk);
    e = exp_words(q.size(), out, burst);
    moved = 0;
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    for (i = 0; i < 400; i++) begin
      @(negedge sys_clk);
      if (busy === 1'b0) break;
    end
    if (i == 400) begin
      bad_count++;
      $display("mismatch %0t transfer hung", $time);
      finish_test();
    end
    chk_word(fbp_word_t'(moved), fbp_word_t'(e));
    chk_bit(fbp_link_if_i.transferDirection, out);
    tot += moved;
  endtask : xfer
  initial begin
    rst = 1'b1;
    outputMode = 1'b0;
    frontShiftIn = 1'b0;
    frontShiftOut = 1'b0;
    start = 1'b0;
    preferBurst = 1'b0;
    frontDataIn = 16'h0000;
    txData = 16'h0100;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk_bit(fbp_link_if_i.transferDirection, 1'b0);
    chk_bit(frontInputReady, 1'b1);
    chk_bit(frontOutputReady, 1'b0);
    foreach (rows[r]) begin
      tot = 0;
      repeat (rows[r].n) xfer(rows[r].out, rows[r].burst);
      chk_word(fbp_word_t'(tot), fbp_word_t'(rows[r].tot));
    end
    repeat (2) xfer(1'b1, 1'b0);
    repeat (2) begin
      @(negedge sys_clk);
      chk_word(frontDataOut, q[0]);
      @(posedge sys_clk);
      frontShiftOut <= 1'b1;
      void'(q.pop_front());
      @(posedge sys_clk);
      frontShiftOut <= 1'b0;
    end
    @(negedge sys_clk);
    chk_bit(frontOutputReady, 1'b0);
    @(posedge sys_clk);
    outputMode <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      @(posedge sys_clk);
      frontShiftIn <= 1'b1;
      frontDataIn <= 16'h0A00 + fbp_word_t'(i);
      q.push_back(16'h0A00 + fbp_word_t'(i));
      @(posedge sys_clk);
      frontShiftIn <= 1'b0;
    end
    xfer(1'b0, 1'b1);
    xfer(1'b0, 1'b0);
    @(posedge sys_clk);
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    rst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk_bit(fbp_link_if_i.unaryAddressResponse, 1'b0);
    chk_bit(frontOutputReady, 1'b0);
    chk_bit(frontInputReady, 1'b1);
    chk_bit(busy, 1'b0);
    @(posedge sys_clk);
    rst <= 1'b0;
    q.delete();
    @(negedge sys_clk);
    chk_bit(fbp_link_if_i.sync, 1'b0);
    xfer(1'b1, 1'b0);
    finish_test();
  end
endmodule : fifo_backplane_poll_transfer_tb_top

// ---- logic/fbp_device_end.sv ----
// device end: answers polls and moves words through the fifo
// a sync phase state machine gates every strobe
// assumes frontplane logic on sys_clk drives the user-side handshake
`timescale 1ns/1ps
`include "fbp_defs.svh"
module fbp_device_end #(
  parameter int WIDTH = `FBP_DATA_WIDTH,
  parameter int DEPTH = `FBP_FIFO_DEPTH
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  fbp_link_if.dev                link,
  input  wire logic              outputMode,
  input  wire logic              frontShiftIn,
  input  wire logic [WIDTH-1:0]  frontDataIn,
  input  wire logic              frontShiftOut,
  output logic      [WIDTH-1:0]  frontDataOut,
  output logic                   frontInputReady,
  output logic                   frontOutputReady
);
  localparam int CW = $clog2(DEPTH) + 1;
  localparam logic [5:0] WORD_LIMIT = 6'(`FBP_BURST_MAX);

  // parameter values the logic cannot serve
  if (WIDTH != `FBP_DATA_WIDTH) begin : g_bad_width
    $error("data width must match the link word");
  end
  if (DEPTH < 2 * `FBP_BURST_MIN || (1 << $clog2(DEPTH)) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two of at least 16");
  end
  if (`FBP_BURST_MAX > 63) begin : g_bad_limit
    $error("word counter cannot hold the burst limit");
  end

  // threshold test shared by free space and occupancy
  function automatic logic at_least(input logic [CW-1:0] value, input logic [CW-1:0] limit);
    return value >= limit;
  endfunction : at_least

  // free entries left in the fifo
  function automatic logic [CW-1:0] free_words(input logic [CW-1:0] used);
    return CW'(DEPTH) - used;
  endfunction : free_words

  // fifo side
  logic                    shiftIn;
  logic                    shiftOut;
  logic                    ir;
  logic                    orr;
  logic                    hf;
  logic                    aef;
  logic [WIDTH-1:0]        fifoIn;
  logic [WIDTH-1:0]        fifoOut;
  logic [CW-1:0]           cnt;
  logic                    room8;
  logic                    data8;

  // strobe edge and sync phase
  logic                    strobePrev_q;
  logic                    strobePrev_d;
  logic                    strobeEdge;
  logic                    take;
  fbp_pkg::fbp_dev_phase_t phase_q;
  fbp_pkg::fbp_dev_phase_t phase_d;
  logic [5:0]              words_q;
  logic [5:0]              words_d;

  // registered link outputs
  logic                    answer_q;
  logic                    answer_d;
  logic                    burst_q;
  logic                    burst_d;
  logic                    dir_q;
  logic                    dir_d;
  logic [WIDTH-1:0]        devData_q;
  logic [WIDTH-1:0]        devData_d;

  // storage between backplane and frontplane
  fbp_fifo #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH),
    .GAP   (`FBP_ALMOST_GAP)
  ) u_fifo (
    .sys_clk             (sys_clk),
    .rst                 (rst),
    .shiftIn             (shiftIn),
    .dataIn              (fifoIn),
    .shiftOut            (shiftOut),
    .dataOut             (fifoOut),
    .fifoInputReady      (ir),
    .fifoOutputReady     (orr),
    .fifoHalfFull        (hf),
    .fifoAlmostFullEmpty (aef),
    .count               (cnt)
  );

  // strobe edge detection and sync phase tracking
  always_comb begin
    strobePrev_d = link.ioStrobe;
    strobeEdge   = link.ioStrobe && !strobePrev_q;
    take         = strobeEdge && link.sync && (phase_q == fbp_pkg::FBP_DEV_SYNC) &&
                   (words_q < WORD_LIMIT);
    phase_d      = phase_q;
    words_d      = words_q;
    case (phase_q)
      fbp_pkg::FBP_DEV_IDLE: begin
        words_d = 6'h00;
        if (answer_q)
          phase_d = fbp_pkg::FBP_DEV_OFFER;
      end
      fbp_pkg::FBP_DEV_OFFER: begin
        if (link.sync)
          phase_d = fbp_pkg::FBP_DEV_SYNC;
        else if (!answer_q)
          phase_d = fbp_pkg::FBP_DEV_IDLE;
      end
      fbp_pkg::FBP_DEV_SYNC: begin
        if (take)
          words_d = words_q + 6'h01;
        if (!link.sync)
          phase_d = fbp_pkg::FBP_DEV_IDLE;
      end
      default: begin
        phase_d = fbp_pkg::FBP_DEV_IDLE;
        words_d = 6'h00;
      end
    endcase
  end

  // strobe and phase registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strobePrev_q <= 1'b0;
      phase_q      <= fbp_pkg::FBP_DEV_IDLE;
      words_q      <= 6'h00;
    end else begin
      strobePrev_q <= strobePrev_d;
      phase_q      <= phase_d;
      words_q      <= words_d;
    end
  end

  // direction and fifo steering; direction moves only between phases
  always_comb begin
    dir_d = (phase_q == fbp_pkg::FBP_DEV_IDLE) ? outputMode : dir_q;
    if (dir_q) begin
      shiftIn  = take && ir;
      fifoIn   = link.hostData;
      shiftOut = frontShiftOut && orr;
    end else begin
      shiftIn  = frontShiftIn && ir;
      fifoIn   = frontDataIn;
      shiftOut = take && orr;
    end
    devData_d = (!dir_q && orr) ? fifoOut : devData_q;
  end

  // direction and head word registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dir_q     <= 1'b0;
      devData_q <= '0;
    end else begin
      dir_q     <= dir_d;
      devData_q <= devData_d;
    end
  end

  // poll answers from fifo occupancy
  always_comb begin
    room8    = at_least(free_words(cnt), CW'(`FBP_BURST_MIN));
    data8    = at_least(cnt, CW'(`FBP_BURST_MIN));
    answer_d = 1'b0;
    burst_d  = 1'b0;
    if (link.poll && phase_q != fbp_pkg::FBP_DEV_SYNC) begin
      if (dir_q) begin
        answer_d = ir && room8;
        burst_d  = ir && room8 && !hf && !aef;
      end else begin
        answer_d = orr;
        burst_d  = data8;
      end
    end
  end

  // answer registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      answer_q <= 1'b0;
      burst_q  <= 1'b0;
    end else begin
      answer_q <= answer_d;
      burst_q  <= burst_d;
    end
  end

  // link and frontplane outputs
  assign link.unaryAddressResponse = answer_q;
  assign link.burstRequest         = burst_q;
  assign link.transferDirection    = dir_q;
  assign link.devData              = devData_q;
  assign frontDataOut              = fifoOut;
  assign frontInputReady           = ir && !dir_q;
  assign frontOutputReady          = orr && dir_q;
endmodule : fbp_device_end

// ---- logic/fbp_fifo.sv ----
// flip-flop fifo with occupancy count and level flags
// assumes one clock, synchronous active-high reset
`timescale 1ns/1ps
`include "fbp_defs.svh"
module fbp_fifo #(
  parameter int WIDTH = `FBP_DATA_WIDTH,
  parameter int DEPTH = `FBP_FIFO_DEPTH,
  parameter int GAP   = `FBP_ALMOST_GAP
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              shiftIn,
  input  wire logic [WIDTH-1:0]  dataIn,
  input  wire logic              shiftOut,
  output logic      [WIDTH-1:0]  dataOut,
  output logic                   fifoInputReady,
  output logic                   fifoOutputReady,
  output logic                   fifoHalfFull,
  output logic                   fifoAlmostFullEmpty,
  output logic      [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 * `FBP_BURST_MIN || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("fifo depth must be a power of two of at least 16");
  end
  if (GAP < 1 || GAP >= DEPTH / 2) begin : g_bad_gap
    $error("almost gap must lie below half the depth");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
  logic [AW:0]      cnt_q, cnt_d;
  logic             doIn, doOut;
  always_comb begin
    doIn    = shiftIn && (cnt_q != (AW+1)'(DEPTH));
    doOut   = shiftOut && (cnt_q != '0);
    wrPtr_d = doIn ? wrPtr_q + AW'(1) : wrPtr_q;
    rdPtr_d = doOut ? rdPtr_q + AW'(1) : rdPtr_q;
    cnt_d   = cnt_q + (AW+1)'(doIn) - (AW+1)'(doOut);
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      cnt_q   <= '0;
    end else begin
      wrPtr_q <= wrPtr_d;
      rdPtr_q <= rdPtr_d;
      cnt_q   <= cnt_d;
    end
    if (doIn)
      mem_q[wrPtr_q] <= dataIn;
  end
  assign dataOut             = mem_q[rdPtr_q];
  assign fifoInputReady      = (cnt_q != (AW+1)'(DEPTH));
  assign fifoOutputReady     = (cnt_q != '0);
  assign fifoHalfFull        = (cnt_q >= (AW+1)'(DEPTH / 2));
  assign fifoAlmostFullEmpty = (cnt_q <= (AW+1)'(GAP)) ||
                               (cnt_q >= (AW+1)'(DEPTH - GAP));
  assign count               = cnt_q;
endmodule : fbp_fifo

// ---- logic/fbp_host_end.sv ----
// host channel end: polls, opens a sync phase, strobes words
// assumes user side supplies words for output and takes input words
`timescale 1ns/1ps
`include "fbp_defs.svh"
module fbp_host_end #(
  parameter int WIDTH     = `FBP_DATA_WIDTH,
  parameter int BURST_LEN = `FBP_BURST_MAX
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  fbp_link_if.host               link,
  input  wire logic              start,
  input  wire logic              preferBurst,
  input  wire logic [WIDTH-1:0]  txData,
  output logic                   txTaken,
  output logic      [WIDTH-1:0]  rxData,
  output logic                   rxValid,
  output logic                   busy
);
  if (BURST_LEN < `FBP_BURST_MIN || BURST_LEN > `FBP_BURST_MAX) begin : g_bad_burst
    $error("burst length must lie between 8 and 32");
  end
  fbp_pkg::fbp_host_state_t state_q, state_d;
  logic [5:0]       left_q, left_d;
  logic             strobe_q, strobe_d, isBurst_q, isBurst_d, sync_d, sync_q;
  logic [WIDTH-1:0] rx_q, rx_d, tx_q, tx_d;
  logic             rxv_q, rxv_d, wait_q, wait_d;
  always_comb begin
    state_d   = state_q;
    left_d    = left_q;
    strobe_d  = 1'b0;
    sync_d    = sync_q;
    isBurst_d = isBurst_q;
    rx_d      = rx_q;
    tx_d      = tx_q;
    rxv_d     = 1'b0;
    wait_d    = 1'b0;
    case (state_q)
      fbp_pkg::FBP_IDLE: begin
        if (start)
          state_d = fbp_pkg::FBP_POLL;
      end
      fbp_pkg::FBP_POLL: begin
        wait_d = !wait_q;
        if (wait_q && link.unaryAddressResponse) begin
          isBurst_d = link.burstRequest && preferBurst;
          left_d    = link.burstRequest && preferBurst ? 6'(BURST_LEN) : 6'd1;
          sync_d    = 1'b1;
          state_d   = fbp_pkg::FBP_SYNC;
        end else if (wait_q) begin
          state_d = fbp_pkg::FBP_IDLE;
        end
      end
      fbp_pkg::FBP_SYNC: begin
        if (!strobe_q) begin
          strobe_d = 1'b1;
          tx_d     = txData;
        end else begin
          left_d = left_q - 6'd1;
          if (!link.transferDirection) begin
            rx_d  = link.devData;
            rxv_d = 1'b1;
          end
          if (left_q == 6'd1)
            state_d = fbp_pkg::FBP_DONE;
        end
      end
      fbp_pkg::FBP_DONE: begin
        sync_d  = 1'b0;
        state_d = fbp_pkg::FBP_IDLE;
      end
      default: state_d = fbp_pkg::FBP_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q   <= fbp_pkg::FBP_IDLE;
      left_q    <= '0;
      strobe_q  <= 1'b0;
      sync_q    <= 1'b0;
      isBurst_q <= 1'b0;
      rx_q      <= '0;
      tx_q      <= '0;
      rxv_q     <= 1'b0;
      wait_q    <= 1'b0;
    end else begin
      state_q   <= state_d;
      left_q    <= left_d;
      strobe_q  <= strobe_d;
      sync_q    <= sync_d;
      isBurst_q <= isBurst_d;
      rx_q      <= rx_d;
      tx_q      <= tx_d;
      rxv_q     <= rxv_d;
      wait_q    <= wait_d;
    end
  end
  assign link.poll     = (state_q == fbp_pkg::FBP_POLL);
  assign link.sync     = sync_q;
  assign link.ioStrobe = strobe_q;
  assign link.hostData = tx_q;
  assign txTaken       = strobe_q && link.transferDirection;
  assign rxData        = rx_q;
  assign rxValid       = rxv_q;
  assign busy          = (state_q != fbp_pkg::FBP_IDLE);
endmodule : fbp_host_end

// ---- pkg/fbp_defs.svh ----
// constants for the backplane poll/transfer block
// assumes inclusion by bare name; a guard prevents double inclusion
// Overview of operation
// - transfers happen only inside a sync phase
// - bursts of 8 to 32 words, or single words
// - direction output selects input or output
// - output: answer poll when eight words free
// - output: burst request when both flags zero
// - output: ignore polls under eight free words
// - output: one word accepted per strobe pulse
// - burst: sync held until last word, max 32
// - single word: sync pulsed once per word
// - software should prefer burst mode
// - output word waits at head for frontplane
// - input word waits at head for backplane
// - input: answer poll, one word per strobe
// - input-ready on space, output-ready on data; code raises input-ready only in input mode, output-ready only in output mode
// - poll answer follows input/output ready
`ifndef FBP_DEFS_SVH
`define FBP_DEFS_SVH
`define FBP_BURST_MIN   8
`define FBP_BURST_MAX   32
`define FBP_FIFO_DEPTH  64
`define FBP_DATA_WIDTH  16
`define FBP_ALMOST_GAP  8
`endif

// ---- pkg/fbp_link_if.sv ----
// backplane link between the host channel end and the device end
// assumes one clock sys_clk for both parties
`timescale 1ns/1ps
`include "fbp_defs.svh"
interface fbp_link_if;
  logic                        poll;
  logic                        unaryAddressResponse;
  logic                        burstRequest;
  logic                        sync;
  logic                        ioStrobe;
  logic                        transferDirection;
  logic [`FBP_DATA_WIDTH-1:0]  hostData;
  logic [`FBP_DATA_WIDTH-1:0]  devData;
  modport dev (
    input  poll,
    input  sync,
    input  ioStrobe,
    input  hostData,
    output unaryAddressResponse,
    output burstRequest,
    output transferDirection,
    output devData
  );
  modport host (
    output poll,
    output sync,
    output ioStrobe,
    output hostData,
    input  unaryAddressResponse,
    input  burstRequest,
    input  transferDirection,
    input  devData
  );
endinterface : fbp_link_if

// ---- pkg/fbp_pkg.sv ----
// types shared by both ends of the backplane link
// assumes fbp_defs.svh is on the include path
package fbp_pkg;
  typedef enum logic [1:0] {
    FBP_IDLE  = 2'b00,
    FBP_POLL  = 2'b01,
    FBP_SYNC  = 2'b10,
    FBP_DONE  = 2'b11
  } fbp_host_state_t;
  typedef enum logic [1:0] {
    FBP_DEV_IDLE  = 2'b00,
    FBP_DEV_OFFER = 2'b01,
    FBP_DEV_SYNC  = 2'b10
  } fbp_dev_phase_t;
endpackage : fbp_pkg
